// ### dv/pdfir_src.sv
// upstream sample source: one sample per clock in one of three patterns
// assumes the filter samples on the rising edge of the same clock
`default_nettype none
module pdfir_src import pdfir_pkg::*; (
    input  wire logic              clk_in,
    input  wire logic [1:0]        pat_in,
    output var  logic [DATA_W-1:0] sample_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned cnt = 0;
    initial sample_out = '0;
    // a converter never pauses, so a new sample follows every edge without a gap
    always @(posedge clk_in) begin
        cnt <= cnt + 1;
        case (pat_in)
            2'h0: sample_out <= #1 DATA_W'(cnt * 32'h0000_2F13);
            2'h1: sample_out <= #1 cnt[0] ? 18'h1FFFF : 18'h20000;
            default: sample_out <= #1 (cnt % 7 == 0) ? 18'h00001 : 18'h00000;
        endcase
    end
endmodule
`default_nettype wire

// ### dv/test_polyphase_decimation_fir.sv
// self-checking bench: source model, coefficient writer, per-edge scoreboard
// assumes the contract timing of the filter top and its package widths
`default_nettype none
module test_polyphase_decimation_fir import pdfir_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic [DATA_W-1:0]        sample;
    logic                     coef_we = 1'b0;
    logic [COEF_ADDR_W-1:0]   coef_addr = '0;
    logic [COEF_W-1:0]        coef_data = '0;
    logic [ACC_W-1:0]         dout;
    logic [ACC_W-1:0]         last_out = '0;
    logic                     dvalid;
    logic [1:0]               pat = 2'h0;
    logic signed [COEF_W-1:0] h [0:15];
    logic signed [DATA_W-1:0] xh [0:4095];
    int                       edge_n = 0;
    int                       cycles = 0;
    int                       fails = 0;
    int                       checked = 0;
    int                       outs = 0;
    bit                       arm = 1'b0;
    always #20 clk = ~clk;
    pdfir_top uut (
        .CLK_SYS_IN     (clk),
        .SYS_RST_IN     (rst),
        .SAMPLE_IN      (sample),
        .COEF_WE_IN     (coef_we),
        .COEF_ADDR_IN   (coef_addr),
        .COEF_DATA_IN   (coef_data),
        .DATA_OUT       (dout),
        .DATA_VALID_OUT (dvalid)
    );
    pdfir_src src (
        .clk_in     (clk),
        .pat_in     (pat),
        .sample_out (sample)
    );
    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // scoreboard reads design outputs before the edge's own updates land
    always @(posedge clk) begin
        longint acc;
        logic [ACC_W-1:0] ev;
        logic ev_v;
        cycles = cycles + 1;
        if (cycles > 2000) begin
            fails = fails + 1;
            finish_test();
        end else if (rst) begin
            edge_n = 0;
        end else begin
            xh[edge_n % 4096] = $signed(sample);
            checked = checked + 2;
            // a pulse launched at edge 4n + 4 shows here one edge later
            ev_v = (edge_n >= 5 && edge_n % 4 == 1);
            if (dvalid !== ev_v) begin
                $display("[ERR] DATA_VALID_OUT exp %0b got %0b", ev_v, dvalid);
                fails = fails + 1;
            end
            ev = (edge_n == 0) ? '0 : last_out;
            if (dvalid !== 1'b1 && dout !== ev) begin
                $display("[ERR] DATA_OUT hold exp %h got %h", ev, dout);
                fails = fails + 1;
            end
            // full-precision reference; window limited to the sixteen newest samples
            if (dvalid === 1'b1 && arm) begin
                acc = 0;
                // the newest sample in this result was taken seven edges ago
                for (int i = 0; i < FIR_LEN; i++)
                    if (edge_n - 7 - i >= 0) acc += h[i] * xh[edge_n - 7 - i];
                ev = acc[ACC_W-1:0];
                outs = outs + 1;
                if (dout !== ev) begin
                    $display("[ERR] DATA_OUT exp %h got %h", ev, dout);
                    fails = fails + 1;
                end
            end
            last_out = dout;
            edge_n = edge_n + 1;
        end
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // reset also clears coefficients, so the reference set goes to zero too
    task automatic do_reset(input int n);
        arm = 1'b0;
        rst = 1'b1;
        wait_cyc(n);
        rst = 1'b0;
        foreach (h[i]) h[i] = '0;
        arm = 1'b1;
    endtask
    // back-to-back writes mid-stream; outputs that mix sets are not judged
    task automatic load_coefs(input int kind);
        arm = 1'b0;
        for (int i = 0; i < FIR_LEN; i++) begin
            coef_we = 1'b1;
            coef_addr = COEF_ADDR_W'(i);
            coef_data = kind == 0 ? COEF_W'(i * 32'h3F01 + 1) : (i[0] ? 18'h1FFFF : 18'h20000);
            h[i] = $signed(coef_data);
            wait_cyc(1);
        end
        coef_we = 1'b0;
        wait_cyc(16);
        arm = 1'b1;
    endtask
    task automatic run_check(input int n);
        int o0;
        o0 = outs;
        wait_cyc(n);
        checked = checked + 1;
        if (outs == o0) begin
            $display("[ERR] outputs judged exp >0 got %0d", outs - o0);
            fails = fails + 1;
        end
    endtask
    task automatic t_ramp();
        load_coefs(0);
        pat = 2'h0;
        run_check(200);
    endtask
    task automatic t_impulse();
        pat = 2'h2;
        run_check(120);
    endtask
    task automatic t_fullscale();
        load_coefs(1);
        pat = 2'h1;
        run_check(120);
    endtask
    task automatic t_midreset();
        do_reset(3);
        run_check(60);
        load_coefs(0);
        pat = 2'h2;
        run_check(100);
    endtask
    initial begin
        do_reset(8);
        t_ramp();
        t_impulse();
        t_fullscale();
        t_midreset();
        finish_test();
    end
endmodule
`default_nettype wire

// ### hw/pdfir_mac.sv
// shared 4-tap multiply-add with input, pipeline and output registers
// assumes the caller keeps taps, coefficients and tag aligned in one word
`default_nettype none
module pdfir_mac (
    input  wire logic                      clk_in,
    input  wire logic                      rst_in,
    input  wire pdfir_pkg::pdfir_mac_in_s  mac_in,
    output var  pdfir_pkg::pdfir_mac_out_s mac_out
);
    import pdfir_pkg::*;

    pdfir_mac_state_s st_reg;
    pdfir_mac_state_s st_next;

    // three register stages keep the multiplier off the critical path
    always_comb begin
        logic [SUM_W-1:0] sum_v;
        sum_v    = '0;
        st_next  = st_reg;
        st_next.in_r     = mac_in;                  // data and coefficient input registers
        st_next.prod_tag = st_reg.in_r.tag;
        for (int n = 0; n < SUB_LEN; n++) begin
            // 18x18 signed product fits 36 bits exactly
            st_next.prod[n] = $signed({{COEF_W{st_reg.in_r.taps[n][DATA_W-1]}},
                                       st_reg.in_r.taps[n]}) *
                              $signed({{DATA_W{st_reg.in_r.coefs[n][COEF_W-1]}},
                                       st_reg.in_r.coefs[n]});
            sum_v = sum_v + SUM_W'($signed(st_reg.prod[n]));
        end
        st_next.out_r.tag = st_reg.prod_tag;
        st_next.out_r.sum = sum_v;
    end

    // state register on the fast clock
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mac_out = st_reg.out_r;

    // the tag leaves exactly three cycles after it entered
    mac_latency_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !$past(rst_in, 3) |-> mac_out.tag == $past(mac_in.tag, 3))
        else $error("mac tag latency wrong");

    // product 0 equals tap 0 times coefficient 0 from two cycles back
    mac_product_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !$past(rst_in, 2) |-> $signed(st_reg.prod[0]) ==
            $signed($past(mac_in.taps[0], 2)) * $signed($past(mac_in.coefs[0], 2)))
        else $error("mac product mismatch");
endmodule
`default_nettype wire

// ### hw/pdfir_pkg.sv
// constants, types and state layouts for the polyphase decimation filter
// assumes one system clock standing in for the fast (4x) filter clock
`default_nettype none
package pdfir_pkg;
    localparam int DEC_FACTOR  = 4;                      // decimation factor D
    localparam int FIR_LEN     = 16;                     // prototype filter length L
    localparam int SUB_LEN     = FIR_LEN / DEC_FACTOR;   // taps per sub-filter
    localparam int DATA_W      = 18;
    localparam int COEF_W      = 18;
    localparam int PROD_W      = DATA_W + COEF_W;
    localparam int SUM_W       = PROD_W + 2;             // four products
    localparam int ACC_W       = SUM_W + 2;              // four partial sums
    localparam int PHASE_W     = 2;
    localparam int COEF_ADDR_W = 4;
    localparam int MAC_LATENCY = 3;                      // input, product, sum registers

    localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;   // counter starts at zero
    localparam logic [PHASE_W-1:0] PHASE_LAST  = 2'h3;   // D-1, first set of each output

    typedef logic [PHASE_W-1:0] pdfir_phase_t;

    typedef struct packed {
        logic         valid;
        pdfir_phase_t phase;
    } pdfir_tag_s;

    typedef struct packed {
        pdfir_tag_s                       tag;
        logic [SUB_LEN-1:0][DATA_W-1:0]   taps;
        logic [SUB_LEN-1:0][COEF_W-1:0]   coefs;
    } pdfir_mac_in_s;

    typedef struct packed {
        pdfir_tag_s       tag;
        logic [SUM_W-1:0] sum;
    } pdfir_mac_out_s;

    typedef struct packed {
        pdfir_mac_in_s                    in_r;
        pdfir_tag_s                       prod_tag;
        logic [SUB_LEN-1:0][PROD_W-1:0]   prod;
        pdfir_mac_out_s                   out_r;
    } pdfir_mac_state_s;

    typedef struct packed {
        logic [DATA_W-1:0]                              sync1;
        logic [DATA_W-1:0]                              sync2;
        pdfir_phase_t                                   phase;
        logic [DEC_FACTOR-1:0][SUB_LEN-1:0][DATA_W-1:0] lines;
        logic [SUB_LEN-1:0][DEC_FACTOR-1:0][COEF_W-1:0] coefs;
        pdfir_mac_in_s                                  mac_in;
        logic [ACC_W-1:0]                               acc;
        logic [ACC_W-1:0]                               out_data;
        logic                                           out_valid;
    } pdfir_state_s;
endpackage
`default_nettype wire

// ### hw/pdfir_top.sv
// polyphase decimation filter, D = 4, 16 taps, one shared 4-tap multiply-add
// assumes one sample per clock on SAMPLE_IN and a coefficient writer on this clock
`default_nettype none
module pdfir_top (
    input  wire logic                                 CLK_SYS_IN,
    input  wire logic                                 SYS_RST_IN,
    input  wire logic [pdfir_pkg::DATA_W-1:0]         SAMPLE_IN,
    input  wire logic                                 COEF_WE_IN,
    input  wire logic [pdfir_pkg::COEF_ADDR_W-1:0]    COEF_ADDR_IN,
    input  wire logic [pdfir_pkg::COEF_W-1:0]         COEF_DATA_IN,
    output var  logic [pdfir_pkg::ACC_W-1:0]          DATA_OUT,
    output var  logic                                 DATA_VALID_OUT
);
    import pdfir_pkg::*;

    pdfir_state_s            st_reg;
    pdfir_state_s            st_next;
    pdfir_mac_out_s          mac_out;
    logic [DEC_FACTOR-1:0]   line_we;
    logic [ACC_W-1:0]        sum_ext;

    // demultiplexer: one write enable per sub-filter line
    for (genvar k = 0; k < DEC_FACTOR; k++) begin : g_demux
        assign line_we[k] = (st_reg.phase == PHASE_W'(k));

        // a line that was not selected keeps all its samples
        line_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
            !$past(SYS_RST_IN) && !$past(line_we[k]) |-> $stable(st_reg.lines[k]))
            else $error("unselected sample line changed");

        // the selected line takes the synchronised sample as its newest tap
        line_take_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
            !$past(SYS_RST_IN) && $past(line_we[k]) |->
                st_reg.lines[k][0] == $past(st_reg.sync2))
            else $error("selected line missed the new sample");
    end

    assign sum_ext = ACC_W'($signed(mac_out.sum));

    // next-state logic for the whole datapath
    always_comb begin
        st_next = st_reg;
        // the source is off-chip, so two flops before anything reads it
        st_next.sync1 = SAMPLE_IN;
        st_next.sync2 = st_reg.sync1;
        // one phase step per sample, downward modulo D
        st_next.phase = (st_reg.phase == PHASE_RESET) ? PHASE_LAST
                                                      : st_reg.phase - 2'h1;
        // only the selected line shifts in the new sample
        for (int k = 0; k < DEC_FACTOR; k++) begin
            if (line_we[k]) begin
                st_next.lines[k] = {st_reg.lines[k][SUB_LEN-2:0], st_reg.sync2};
            end
        end
        // coefficient h(i) lives in memory i/D at entry i mod D
        if (COEF_WE_IN) begin
            st_next.coefs[COEF_ADDR_IN[3:2]][COEF_ADDR_IN[1:0]] = COEF_DATA_IN;
        end
        // feed the shared datapath with the line just updated and its set;
        // the set order follows the phase counter, 0, 3, 2, 1
        st_next.mac_in.tag.valid = 1'b1;
        st_next.mac_in.tag.phase = st_reg.phase;
        st_next.mac_in.taps      = st_next.lines[st_reg.phase];
        for (int n = 0; n < SUB_LEN; n++) begin
            st_next.mac_in.coefs[n] = st_reg.coefs[n][st_reg.phase];
        end
        // an output appears six edges after its newest sample is taken; the first
        // one after reset carries only zero partials and so reads zero
        // accumulate phases 3, 2, 1, 0; capture on phase 0 only
        st_next.out_valid = 1'b0;
        if (mac_out.tag.valid) begin
            if (mac_out.tag.phase == PHASE_LAST) begin
                st_next.acc = sum_ext;                 // fresh sum
            end else begin
                st_next.acc = st_reg.acc + sum_ext;
            end
            if (mac_out.tag.phase == PHASE_RESET) begin
                st_next.out_data  = st_next.acc;       // slow-rate output
                st_next.out_valid = 1'b1;
            end
        end
    end

    // every register runs on the fast clock; the output one changes 1 in 4
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    pdfir_mac u_mac (
        .clk_in  (CLK_SYS_IN),
        .rst_in  (SYS_RST_IN),
        .mac_in  (st_reg.mac_in),
        .mac_out (mac_out)
    );

    // outputs come straight from the state register
    assign DATA_OUT       = st_reg.out_data;
    assign DATA_VALID_OUT = st_reg.out_valid;

    // exactly one line is selected on every edge
    demux_onehot_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        $onehot(line_we))
        else $error("sample routed to zero or several lines");

    // the selector steps down by one on every edge
    phase_down_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) |-> st_reg.phase == $past(st_reg.phase) - 2'h1)
        else $error("phase counter not counting down");

    // set 3 follows set 0, closing one output and opening the next
    coef_order_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        st_reg.mac_in.tag.valid && st_reg.mac_in.tag.phase == PHASE_RESET
        |=> st_reg.mac_in.tag.phase == PHASE_LAST)
        else $error("coefficient set order broken");

    // the datapath gets entry k of memory 2 for phase k
    coef_select_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) && !$past(COEF_WE_IN) |->
            st_reg.mac_in.coefs[2] == st_reg.coefs[2][st_reg.mac_in.tag.phase])
        else $error("wrong coefficient memory entry");

    // one pulse in every four edges, never two in a row
    out_spacing_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        DATA_VALID_OUT |=> !DATA_VALID_OUT [*3] ##1 DATA_VALID_OUT)
        else $error("output not once every four cycles");

    // between pulses the output stands still
    out_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !DATA_VALID_OUT |-> $stable(DATA_OUT))
        else $error("output changed between captures");

    // a result is the four partials that led up to it
    out_sum_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        DATA_VALID_OUT && !$past(SYS_RST_IN, 4) |-> DATA_OUT ==
            $past(sum_ext, 1) + $past(sum_ext, 2) + $past(sum_ext, 3) + $past(sum_ext, 4))
        else $error("output is not the sum of four partials");

    // the phase-3 partial starts a fresh sum
    acc_restart_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        mac_out.tag.valid && mac_out.tag.phase == PHASE_LAST |=> st_reg.acc == $past(sum_ext))
        else $error("accumulator did not restart");

    // a pulse only follows a phase-0 partial
    out_phase_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        DATA_VALID_OUT |-> $past(mac_out.tag.phase) == PHASE_RESET && $past(mac_out.tag.valid))
        else $error("output captured at a discarded instant");

    // the sample reaches the lines only through both flops
    sync_in_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2) |-> st_reg.sync2 == $past(SAMPLE_IN, 2))
        else $error("sample synchroniser depth wrong");

    // the selector leaves reset at zero
    phase_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        $past(SYS_RST_IN) |-> st_reg.phase == PHASE_RESET)
        else $error("phase counter did not start at zero");

    // the set handed to the datapath follows the selector one edge later
    set_phase_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) |-> st_reg.mac_in.tag.phase == $past(st_reg.phase))
        else $error("coefficient set out of step with selector");

    // taps come from the line just written, already holding the new sample
    tap_feed_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) |-> st_reg.mac_in.taps == st_reg.lines[st_reg.mac_in.tag.phase])
        else $error("datapath taps differ from the selected line");

    // a write lands in memory i/D at entry i mod D
    coef_store_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) && $past(COEF_WE_IN) |->
            st_reg.coefs[$past(COEF_ADDR_IN[3:2])][$past(COEF_ADDR_IN[1:0])] ==
            $past(COEF_DATA_IN))
        else $error("coefficient write landed in the wrong place");

    // with no write the stored sets stay put
    coef_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !$past(SYS_RST_IN) && !$past(COEF_WE_IN) |-> $stable(st_reg.coefs))
        else $error("coefficient store changed without a write");

    // phases 2, 1 and 0 add onto the running sum
    acc_add_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        mac_out.tag.valid && mac_out.tag.phase != PHASE_LAST |=>
            st_reg.acc == $past(st_reg.acc) + $past(sum_ext))
        else $error("partial result not added");

    // with no partial in flight the sum must not move
    acc_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !mac_out.tag.valid |=> $stable(st_reg.acc))
        else $error("accumulator moved without a partial");

    // the output register takes the closed sum and nothing else
    out_capture_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        DATA_VALID_OUT |-> DATA_OUT == st_reg.acc)
        else $error("output differs from the closed sum");

    // reset leaves the output at zero with no pulse
    out_reset_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        $past(SYS_RST_IN) |-> DATA_OUT == '0 && !DATA_VALID_OUT)
        else $error("output not cleared by reset");

    // no pulse unless a phase-0 partial has just closed a sum
    out_quiet_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
        !(mac_out.tag.valid && mac_out.tag.phase == PHASE_RESET) |=> !DATA_VALID_OUT)
        else $error("output pulse at a discarded instant");
endmodule
`default_nettype wire
